// ===== t2cr_top.sv
// Timer 2 with capture, auto-reload and baud-rate modes, plus timer 0/1 toggle pins.
`timescale 1ns/1ps
`include "t2cr_params.svh"
module t2cr_top
	import t2cr_pkg::*;
#(
	parameter int NU = 2
) (
	input  wire logic                 clock_i,
	input  wire logic                 rstn_i,
	input  wire logic [`T2CR_AW-1:0]  addr_i,
	input  wire logic [7:0]           wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic      [7:0]           rdata_o,
	input  wire logic                 tick_i,
	input  wire logic                 count_pin_i,
	input  wire logic                 trigger_pin_i,
	input  wire logic                 t1_ovf_i,
	input  wire logic [1:0]           tmr01_ovf_i,
	input  wire logic [1:0]           port_latch_i,
	output logic      [1:0]           tmr01_pin_o,
	output logic                      irq_req_o,
	output logic      [NU-1:0]        uart_tx_baud_o,
	output logic      [NU-1:0]        uart_rx_baud_o
);
	// ---------------------------------------------------------------
	// Register state.
	// ---------------------------------------------------------------
	logic          ovf_flag_r;
	logic          trg_flag_r;
	logic          trg_en_r;
	logic          run_r;
	logic          cts_r;
	logic          cprl_r;
	logic          down_count_enable_r;
	logic [NU-1:0] rx_sel_r;
	logic [NU-1:0] tx_sel_r;
	logic [1:0]    oe_sel_r;
	logic [15:0]   cnt_r;
	logic [15:0]   cap_r;
	logic [7:0]    rdata_r;
	logic          irq_r;
	logic [NU-1:0] tx_baud_r;
	logic [NU-1:0] rx_baud_r;

	// ---------------------------------------------------------------
	// Decode of bus strobes, mode and count events.
	// ---------------------------------------------------------------
	t2cr_mode_t mode;
	logic [1:0] falls;
	logic       wr_ctrl;
	logic       wr_lo;
	logic       wr_hi;
	logic       cnt_wr;
	logic       baud;
	logic       dcmode;
	logic       src;
	logic       step;
	logic       up;
	logic       ovf;
	logic       unf;
	logic       ext_ev;

	t2cr_fall #(
		.W(2)
	) u_fall (
		.clock_i(clock_i),
		.rstn_i (rstn_i),
		.pin_i  ({trigger_pin_i, count_pin_i}),
		.fall_o (falls)
	);

	assign wr_ctrl = wr_i && (addr_i == `T2CR_ADDR_CTRL);
	assign wr_lo   = wr_i && (addr_i == `T2CR_ADDR_CNT_LO);
	assign wr_hi   = wr_i && (addr_i == `T2CR_ADDR_CNT_HI);
	assign cnt_wr  = wr_lo || wr_hi;
	assign baud    = |{rx_sel_r, tx_sel_r};

	// Stop outranks every other mode, baud outranks capture.
	always_comb begin
		if (!run_r) begin
			mode = T2CR_STOP;
		end else if (baud) begin
			mode = T2CR_BAUD;
		end else if (cprl_r) begin
			mode = T2CR_CAPTURE;
		end else begin
			mode = T2CR_RELOAD;
		end
	end

	assign dcmode = (mode == T2CR_RELOAD) && down_count_enable_r;
	// Baud mode ignores the counter select so the bit rate stays exact.
	assign src    = (cts_r && !baud) ? falls[0] : tick_i;
	assign step   = (mode != T2CR_STOP) && src;
	assign up     = !dcmode || trigger_pin_i;
	assign ovf    = step && up && (cnt_r == `T2CR_CNT_MAX);
	assign unf    = step && !up && (cnt_r == cap_r);
	// In down-count mode the trigger pin is the direction, not an event.
	assign ext_ev = falls[1] && trg_en_r && !dcmode &&
	                ((mode == T2CR_CAPTURE) || (mode == T2CR_RELOAD));

	// ---------------------------------------------------------------
	// Control bits; hardware flag events win over a same-cycle write.
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{trg_en_r, run_r, cts_r, cprl_r} <= 4'h0;
			rx_sel_r <= '0;
			tx_sel_r <= '0;
			down_count_enable_r   <= 1'b0;
			oe_sel_r <= 2'h0;
		end else if (wr_i) begin
			if (addr_i == `T2CR_ADDR_CTRL) begin
				trg_en_r    <= wdata_i[`T2CR_CTRL_EXEN];
				run_r       <= wdata_i[`T2CR_CTRL_RUN];
				cts_r       <= wdata_i[`T2CR_CTRL_CTS];
				cprl_r      <= wdata_i[`T2CR_CTRL_CPRL];
				rx_sel_r[0] <= wdata_i[`T2CR_CTRL_RX0];
				tx_sel_r[0] <= wdata_i[`T2CR_CTRL_TX0];
			end
			if (addr_i == `T2CR_ADDR_MODE) begin
				rx_sel_r[NU-1] <= wdata_i[`T2CR_MODE_RX1];
				tx_sel_r[NU-1] <= wdata_i[`T2CR_MODE_TX1];
				down_count_enable_r         <= wdata_i[`T2CR_MODE_DOWN_COUNT_ENABLE];
			end
			if (addr_i == `T2CR_ADDR_STATUS) begin
				oe_sel_r <= {wdata_i[`T2CR_STAT_T1OE], wdata_i[`T2CR_STAT_T0OE]};
			end
		end
	end

	// Overflow flag: sticky, cleared only by a software write of zero.
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovf_flag_r <= 1'b0;
		end else if ((ovf || unf) && (mode != T2CR_BAUD)) begin
			ovf_flag_r <= 1'b1;
		end else if (wr_ctrl) begin
			ovf_flag_r <= wdata_i[`T2CR_CTRL_OVF];
		end
	end

	// Trigger flag: set by pin events, or a 17th count bit when counting both ways.
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			trg_flag_r <= 1'b0;
		end else if (dcmode && (ovf || unf)) begin
			trg_flag_r <= ~trg_flag_r;
		end else if (ext_ev) begin
			trg_flag_r <= 1'b1;
		end else if (wr_ctrl) begin
			trg_flag_r <= wdata_i[`T2CR_CTRL_TRG];
		end
	end

	// ---------------------------------------------------------------
	// Count and capture/reload pair. A software write to the count
	// beats a hardware step in the same cycle.
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r <= 16'h0000;
		end else if (cnt_wr) begin
			if (wr_lo) begin
				cnt_r[7:0] <= wdata_i;
			end else begin
				cnt_r[15:8] <= wdata_i;
			end
		end else if (ext_ev && (mode == T2CR_RELOAD)) begin
			cnt_r <= cap_r;
		end else if (ovf) begin
			cnt_r <= (mode == T2CR_CAPTURE) ? 16'h0000 : cap_r;
		end else if (unf) begin
			cnt_r <= `T2CR_CNT_MAX;
		end else if (step) begin
			cnt_r <= up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
		end
	end

	// Capture wins over a same-cycle software write so no event is lost.
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cap_r <= 16'h0000;
		end else if (ext_ev && (mode == T2CR_CAPTURE)) begin
			cap_r <= cnt_r;
		end else if (wr_i && (addr_i == `T2CR_ADDR_CAP_LO)) begin
			cap_r[7:0] <= wdata_i;
		end else if (wr_i && (addr_i == `T2CR_ADDR_CAP_HI)) begin
			cap_r[15:8] <= wdata_i;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt request and UART baud routing.
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= ovf_flag_r || (trg_flag_r && !dcmode);
		end
	end

	for (genvar u = 0; u < NU; u++) begin : g_uart
		always_ff @(posedge clock_i or negedge rstn_i) begin
			if (!rstn_i) begin
				tx_baud_r[u] <= 1'b0;
				rx_baud_r[u] <= 1'b0;
			end else begin
				tx_baud_r[u] <= tx_sel_r[u] ? ovf : t1_ovf_i;
				rx_baud_r[u] <= rx_sel_r[u] ? ovf : t1_ovf_i;
			end
		end
	end

	// ---------------------------------------------------------------
	// Read port: data stand only in the cycle after the strobe.
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_r <= 8'h00;
		end else if (!rd_i) begin
			rdata_r <= 8'h00;
		end else begin
			unique case (addr_i)
				`T2CR_ADDR_CTRL: rdata_r <= {ovf_flag_r, trg_flag_r, rx_sel_r[0], tx_sel_r[0],
				                             trg_en_r, run_r, cts_r, cprl_r};
				`T2CR_ADDR_MODE: rdata_r <= {2'h0, rx_sel_r[NU-1], tx_sel_r[NU-1], 3'h0, down_count_enable_r};
				`T2CR_ADDR_STATUS: rdata_r <= {5'h00, oe_sel_r[1], 1'b0, oe_sel_r[0]};
				`T2CR_ADDR_CNT_LO: rdata_r <= cnt_r[7:0];
				`T2CR_ADDR_CNT_HI: rdata_r <= cnt_r[15:8];
				`T2CR_ADDR_CAP_LO: rdata_r <= cap_r[7:0];
				`T2CR_ADDR_CAP_HI: rdata_r <= cap_r[15:8];
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	// The toggle pins double as the timer 0/1 count inputs outside.
	t2cr_toggle #(
		.N(2)
	) u_tog (
		.clock_i(clock_i),
		.rstn_i (rstn_i),
		.ovf_i  (tmr01_ovf_i),
		.sel_i  (oe_sel_r),
		.latch_i(port_latch_i),
		.pin_o  (tmr01_pin_o)
	);

	assign rdata_o        = rdata_r;
	assign irq_req_o      = irq_r;
	assign uart_tx_baud_o = tx_baud_r;
	assign uart_rx_baud_o = rx_baud_r;

	// ---------------------------------------------------------------
	// Assertions and covers.
	// ---------------------------------------------------------------
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	a_ovf_sets_flag: assert property ((ovf || unf) && mode != T2CR_BAUD |=> ovf_flag_r)
		else $error("overflow flag not set");
	a_src_select: assert property (step && cts_r && !baud |-> $past(count_pin_i) && !count_pin_i)
		else $error("counter step without pin fall");
	a_capture_copy: assert property (ext_ev && mode == T2CR_CAPTURE |=> cap_r == $past(cnt_r))
		else $error("capture missed");
	a_ext_flag: assert property (ext_ev |=> trg_flag_r)
		else $error("trigger flag not set");
	a_reload_ovf: assert property (ovf && mode == T2CR_RELOAD && !cnt_wr && !ext_ev
		|=> cnt_r == $past(cap_r))
		else $error("reload on overflow wrong");
	a_down_unf: assert property (unf && !cnt_wr |=> cnt_r == 16'hffff && ovf_flag_r)
		else $error("underflow reload wrong");
	a_flag_toggle: assert property (dcmode && (ovf || unf) |=> trg_flag_r != $past(trg_flag_r))
		else $error("trigger flag did not toggle");
	a_dc_no_irq: assert property ((dcmode && !ovf_flag_r)[*2] |-> !irq_r)
		else $error("trigger flag raised interrupt");
	a_stop_hold: assert property (mode == T2CR_STOP && !cnt_wr |=> $stable(cnt_r))
		else $error("stopped timer moved");
	a_baud_quiet: assert property (mode == T2CR_BAUD && !ovf_flag_r && !wr_ctrl |=> !ovf_flag_r)
		else $error("baud roll-over set flag");
	a_baud_route: assert property (ovf && tx_sel_r[0] |=> uart_tx_baud_o[0])
		else $error("baud not routed");

	// Count steps, wraps and reloads. Each check leaves out the cycles where a write, or a reload
	// or a wrap that it does not check, takes the count somewhere else.
	a_wrap_capture: assert property (ovf && mode == T2CR_CAPTURE && !cnt_wr |=> cnt_r == 16'h0000)
		else $error("capture mode did not wrap to zero");
	a_trig_reload: assert property (ext_ev && mode == T2CR_RELOAD && !cnt_wr |=> cnt_r == $past(cap_r))
		else $error("trigger fall did not reload");
	a_up_only: assert property (step && mode == T2CR_RELOAD && !down_count_enable_r && !cnt_wr && !ext_ev && !ovf
		|=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("up-only count did not increment");
	a_count_down: assert property (step && !up && !unf && !cnt_wr |=> cnt_r == $past(cnt_r) - 16'h0001)
		else $error("down count did not decrement");
	a_baud_tick: assert property (mode == T2CR_BAUD && tick_i && !cnt_wr && !ovf
		|=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("baud mode missed a tick");
	// The request follows the overflow flag whatever the counting direction.
	a_ovf_irq: assert property (ovf_flag_r |=> irq_req_o)
		else $error("overflow flag raised no request");

	c_capture: cover property (ext_ev && mode == T2CR_CAPTURE);
	c_underflow: cover property (unf);
	c_baud_ovf: cover property (ovf && mode == T2CR_BAUD);
	c_down_wrap: cover property (dcmode && ovf);
	c_trig_reload: cover property (ext_ev && mode == T2CR_RELOAD);
endmodule

// ===== t2cr_params.svh
// Register offsets, field positions and reset values of the timer-2 block.
`ifndef T2CR_PARAMS_SVH
`define T2CR_PARAMS_SVH
`define T2CR_AW            12
`define T2CR_ADDR_STATUS   12'h411
`define T2CR_ADDR_CTRL     12'h418
`define T2CR_ADDR_MODE     12'h419
`define T2CR_ADDR_CNT_LO   12'h458
`define T2CR_ADDR_CNT_HI   12'h459
`define T2CR_ADDR_CAP_LO   12'h45a
`define T2CR_ADDR_CAP_HI   12'h45b
`define T2CR_CTRL_RESET    8'h00
`define T2CR_CTRL_OVF      7
`define T2CR_CTRL_TRG      6
`define T2CR_CTRL_RX0      5
`define T2CR_CTRL_TX0      4
`define T2CR_CTRL_EXEN     3
`define T2CR_CTRL_RUN      2
`define T2CR_CTRL_CTS      1
`define T2CR_CTRL_CPRL     0
`define T2CR_MODE_RX1      5
`define T2CR_MODE_TX1      4
`define T2CR_MODE_DOWN_COUNT_ENABLE     0
`define T2CR_STAT_T1OE     2
`define T2CR_STAT_T0OE     0
`define T2CR_CNT_MAX       16'hffff
`endif

// ===== t2cr_pkg.sv
// Types shared by the timer-2 block.
package t2cr_pkg;
	typedef enum logic [1:0] {
		T2CR_STOP    = 2'b00,
		T2CR_RELOAD  = 2'b01,
		T2CR_CAPTURE = 2'b11,
		T2CR_BAUD    = 2'b10
	} t2cr_mode_t;
endpackage

// ===== t2cr_fall.sv
// Falling-edge detector for a group of synchronous pins.
`timescale 1ns/1ps
module t2cr_fall #(
	parameter int W = 2
) (
	input  wire logic         clock_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] fall_o
);
	logic [W-1:0] prev_r;

	// Previous level resets high so a pin that is low at release counts as a falling edge.
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev_r <= '1;
		end else begin
			prev_r <= pin_i;
		end
	end

	assign fall_o = prev_r & ~pin_i;
endmodule

// ===== t2cr_toggle.sv
// Overflow toggle outputs of timers 0 and 1 with per-timer pin select.
`timescale 1ns/1ps
module t2cr_toggle #(
	parameter int N = 2
) (
	input  wire logic         clock_i,
	input  wire logic         rstn_i,
	input  wire logic [N-1:0] ovf_i,
	input  wire logic [N-1:0] sel_i,
	input  wire logic [N-1:0] latch_i,
	output logic      [N-1:0] pin_o
);
	logic [N-1:0] tog_r;

	// ---------------------------------------------------------------
	// One toggle flop and one pin flop per timer.
	// ---------------------------------------------------------------
	for (genvar i = 0; i < N; i++) begin : g_tog
		always_ff @(posedge clock_i or negedge rstn_i) begin
			if (!rstn_i) begin
				tog_r[i] <= 1'b0;
			end else if (ovf_i[i]) begin
				tog_r[i] <= ~tog_r[i];
			end
		end

		always_ff @(posedge clock_i or negedge rstn_i) begin
			if (!rstn_i) begin
				pin_o[i] <= 1'b1;
			end else begin
				pin_o[i] <= sel_i[i] ? tog_r[i] : latch_i[i];
			end
		end
	end
endmodule

// ===== t2cr_far.sv
// Far-side model of the timer-2 block: count and trigger pins, UART clock inputs.
`timescale 1ns/1ps
module t2cr_far (
	input  wire logic       clock_i,
	input  wire logic [1:0] tx_baud_i,
	input  wire logic [1:0] rx_baud_i,
	output logic            count_pin_o,
	output logic            trigger_pin_o
);
	// Pulses seen per UART clock line, in the order tx0, tx1, rx0, rx1.
	logic [7:0] hits [4] = '{default: 8'h00};

	// Both pins idle high, so that the first low level is a real falling edge.
	initial begin
		count_pin_o = 1'b1;
		trigger_pin_o = 1'b1;
	end

	// A UART only sees single-cycle clock pulses, so each high cycle is one bit time.
	always @(posedge clock_i) begin
		for (int k = 0; k < 2; k++) begin
			hits[k] <= hits[k] + {7'h0, tx_baud_i[k]};
			hits[k+2] <= hits[k+2] + {7'h0, rx_baud_i[k]};
		end
	end

	task automatic set_trig(input logic v);
		@(posedge clock_i);
		trigger_pin_o <= v;
	endtask

	task automatic fall_trig();
		@(posedge clock_i);
		trigger_pin_o <= 1'b0;
		@(posedge clock_i);
		trigger_pin_o <= 1'b1;
		repeat (2) @(posedge clock_i);
	endtask

	task automatic fall_cnt(input int n);
		repeat (n) begin
			@(posedge clock_i);
			count_pin_o <= 1'b0;
			@(posedge clock_i);
			count_pin_o <= 1'b1;
		end
		repeat (2) @(posedge clock_i);
	endtask
endmodule

// ===== test_timer2_capture_reload.sv
// Self-checking bench for the timer-2 capture/reload block.
`timescale 1ns/1ps
`include "t2cr_params.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_timer2_capture_reload;
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  mode;
		logic        trig;
		logic [15:0] cnt;
		logic [15:0] rel;
		logic [3:0]  n;
		logic [15:0] ecnt;
		logic [7:0]  ectrl;
		logic        eirq;
		logic [3:0]  ebaud;
	} t2cr_row_t;

	logic        clock_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [11:0] addr_i = 12'h000;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [7:0]  rdata_o;
	logic        tick_i = 1'b0;
	logic        count_pin;
	logic        trigger_pin;
	logic        t1_ovf_i = 1'b0;
	logic [1:0]  tmr01_ovf_i = 2'b00;
	logic [1:0]  port_latch_i = 2'b11;
	logic [1:0]  tmr01_pin_o;
	logic        irq_req_o;
	logic [1:0]  tx_baud;
	logic [1:0]  rx_baud;
	logic [7:0]  d;
	logic [1:0]  p;
	logic [7:0]  h0 [4];
	t2cr_row_t   r;
	int          failures = 0;
	int          compares = 0;
	// Rows: reload up, capture wrap, down underflow, down overflow, stopped, two baud cases.
	t2cr_row_t rows [7] = '{
		'{8'h04, 8'h00, 1'b1, 16'hfffe, 16'h1234, 4'd3, 16'h1235, 8'h84, 1'b1, 4'h0},
		'{8'h05, 8'h00, 1'b1, 16'hffff, 16'h0000, 4'd2, 16'h0001, 8'h85, 1'b1, 4'h0},
		'{8'h04, 8'h01, 1'b0, 16'h0102, 16'h0100, 4'd3, 16'hffff, 8'hc4, 1'b1, 4'h0},
		'{8'h04, 8'h01, 1'b1, 16'hffff, 16'h0010, 4'd1, 16'h0010, 8'hc4, 1'b1, 4'h0},
		'{8'h00, 8'h00, 1'b1, 16'h1234, 16'h0000, 4'd5, 16'h1234, 8'h00, 1'b0, 4'h0},
		'{8'h15, 8'h00, 1'b1, 16'hfffe, 16'hfff0, 4'd3, 16'hfff1, 8'h15, 1'b0, 4'h1},
		'{8'h06, 8'h20, 1'b1, 16'hfffe, 16'hfff0, 4'd3, 16'hfff1, 8'h06, 1'b0, 4'h8}
	};

	t2cr_top u_dut (
		.clock_i        (clock_i),
		.rstn_i         (rstn_i),
		.addr_i         (addr_i),
		.wdata_i        (wdata_i),
		.wr_i           (wr_i),
		.rd_i           (rd_i),
		.rdata_o        (rdata_o),
		.tick_i         (tick_i),
		.count_pin_i    (count_pin),
		.trigger_pin_i  (trigger_pin),
		.t1_ovf_i       (t1_ovf_i),
		.tmr01_ovf_i    (tmr01_ovf_i),
		.port_latch_i   (port_latch_i),
		.tmr01_pin_o    (tmr01_pin_o),
		.irq_req_o      (irq_req_o),
		.uart_tx_baud_o (tx_baud),
		.uart_rx_baud_o (rx_baud)
	);

	t2cr_far u_far (
		.clock_i       (clock_i),
		.tx_baud_i     (tx_baud),
		.rx_baud_i     (rx_baud),
		.count_pin_o   (count_pin),
		.trigger_pin_o (trigger_pin)
	);

	// ----------------------------------------
	// Clock, bus tasks and closing
	// ----------------------------------------
	// The 100 MHz clock.
	always #5 clock_i = ~clock_i;

	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken just after that edge.
	task automatic rd(input logic [11:0] a, output logic [7:0] v);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask

	task automatic chk16(input logic [11:0] a, input logic [15:0] e);
		logic [7:0] lo;
		logic [7:0] hi;
		rd(a, lo);
		rd(a + 12'h001, hi);
		`CHK("pair", e, {hi, lo})
	endtask

	task automatic load(input logic [7:0] c, input logic [7:0] m, input logic [15:0] cv, input logic [15:0] rv);
		wr(`T2CR_ADDR_MODE, m);
		wr(`T2CR_ADDR_CAP_LO, rv[7:0]);
		wr(`T2CR_ADDR_CAP_HI, rv[15:8]);
		wr(`T2CR_ADDR_CNT_LO, cv[7:0]);
		wr(`T2CR_ADDR_CNT_HI, cv[15:8]);
		wr(`T2CR_ADDR_CTRL, c);
	endtask

	// One extra edge at the end lets the flag and the request settle.
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clock_i);
			tick_i <= 1'b1;
		end
		@(posedge clock_i);
		tick_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic clean(input int i);
		wr(`T2CR_ADDR_CTRL, 8'h00);
		wr(`T2CR_ADDR_MODE, 8'h00);
		$display("test %0d done", i);
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// A hang is cut short well beyond the few hundred cycles the tests need.
	initial begin
		#200us;
		failures++;
		complete_run();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		#12;
		`CHK("reset pins", 2'b11, tmr01_pin_o)
		`CHK("reset irq", 1'b0, irq_req_o)
		repeat (3) @(posedge clock_i);
		rstn_i <= 1'b1;
		rd(`T2CR_ADDR_CTRL, d);
		`CHK("control reset", 8'h00, d)
		wr(12'h7fe, 8'hff);
		rd(12'h7fe, d);
		`CHK("unmapped", 8'h00, d)
		for (int i = 0; i < 7; i++) begin
			r = rows[i];
			u_far.set_trig(r.trig);
			h0 = u_far.hits;
			load(r.ctrl, r.mode, r.cnt, r.rel);
			ticks(r.n);
			chk16(`T2CR_ADDR_CNT_LO, r.ecnt);
			rd(`T2CR_ADDR_CTRL, d);
			`CHK("control", r.ectrl, d)
			`CHK("irq", r.eirq, irq_req_o)
			for (int k = 0; k < 4; k++) begin
				`CHK("baud", {7'h0, r.ebaud[k]}, 8'(u_far.hits[k] - h0[k]))
			end
			clean(i);
		end
		// Capture on a trigger fall.
		load(8'h0d, 8'h00, 16'h0050, 16'h0000);
		ticks(5);
		u_far.fall_trig();
		chk16(`T2CR_ADDR_CAP_LO, 16'h0055);
		rd(`T2CR_ADDR_CTRL, d);
		`CHK("capture flag", 8'h4d, d)
		`CHK("capture irq", 1'b1, irq_req_o)
		clean(7);
		// Reload on a trigger fall.
		load(8'h0c, 8'h00, 16'h0007, 16'h4321);
		u_far.fall_trig();
		chk16(`T2CR_ADDR_CNT_LO, 16'h4321);
		rd(`T2CR_ADDR_CTRL, d);
		`CHK("reload flag", 8'h4c, d)
		clean(8);
		// Counting falls of the count pin.
		load(8'h06, 8'h00, 16'h0000, 16'h0000);
		u_far.fall_cnt(3);
		chk16(`T2CR_ADDR_CNT_LO, 16'h0003);
		clean(9);
		// The trigger flag requests nothing while down counting is on.
		wr(`T2CR_ADDR_MODE, 8'h01);
		// Down counting only counts as a mode while the timer runs; no tick arrives, so the count holds.
		wr(`T2CR_ADDR_CTRL, 8'h44);
		repeat (3) @(posedge clock_i);
		`CHK("down irq", 1'b0, irq_req_o)
		wr(`T2CR_ADDR_MODE, 8'h00);
		repeat (3) @(posedge clock_i);
		`CHK("up irq", 1'b1, irq_req_o)
		clean(10);
		repeat (3) @(posedge clock_i);
		`CHK("cleared irq", 1'b0, irq_req_o)
		// Timer 1 still clocks every direction that is not routed to timer 2.
		wr(`T2CR_ADDR_CTRL, 8'h10);
		h0 = u_far.hits;
		t1_ovf_i <= 1'b1;
		@(posedge clock_i);
		t1_ovf_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		for (int k = 0; k < 4; k++) begin
			`CHK("timer 1 baud", {7'h0, k != 0}, 8'(u_far.hits[k] - h0[k]))
		end
		clean(11);
		// Shared pins: latch data, then overflow toggles.
		port_latch_i <= 2'b10;
		wr(`T2CR_ADDR_STATUS, 8'h00);
		repeat (3) @(posedge clock_i);
		`CHK("latch pins", 2'b10, tmr01_pin_o)
		wr(`T2CR_ADDR_STATUS, 8'h05);
		repeat (3) @(posedge clock_i);
		p = tmr01_pin_o;
		`CHK("toggle start", 2'b00, p)
		tmr01_ovf_i <= 2'b01;
		@(posedge clock_i);
		tmr01_ovf_i <= 2'b10;
		@(posedge clock_i);
		tmr01_ovf_i <= 2'b00;
		repeat (3) @(posedge clock_i);
		`CHK("toggle pins", ~p, tmr01_pin_o)
		$display("test 12 done");
		// A second reset in mid-run clears flags, selects and the count.
		wr(`T2CR_ADDR_CTRL, 8'hc0);
		repeat (2) @(posedge clock_i);
		`CHK("flag irq", 1'b1, irq_req_o)
		rstn_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		`CHK("mid reset pins", 2'b11, tmr01_pin_o)
		`CHK("mid reset irq", 1'b0, irq_req_o)
		rstn_i <= 1'b1;
		rd(`T2CR_ADDR_CTRL, d);
		`CHK("control after reset", 8'h00, d)
		`CHK("pins after reset", 2'b10, tmr01_pin_o)
		chk16(`T2CR_ADDR_CNT_LO, 16'h0000);
		$display("test 13 done");
		complete_run();
	end
endmodule
